//--- rtl/asi_defs.svh
/*
 * Constants of the converter serial interface: sampling chain, control byte
 * layout, bit counts and timing.
 * Assumes a single 125 MHz system clock and inclusion by the design files.
 */
`ifndef ASI_DEFS_SVH
`define ASI_DEFS_SVH

`define ASI_CLK_MHZ      125
`define ASI_CONV_NS      7500
`define ASI_CONV_CYC     ((`ASI_CONV_NS * `ASI_CLK_MHZ + 999) / 1000)
`define ASI_RES_W        10
`define ASI_CNT_W        4
`define ASI_CTRL_BITS    4'h8
`define ASI_TRACK_BIT    4'h5
`define ASI_CNT_ONE      4'h1
`define ASI_DUTY_W       10
`define ASI_DUTY_MAX     10'h3FF
`define ASI_DUTY_LO      14'h0004
`define ASI_DUTY_HI      14'h0006
`define ASI_DUTY_SCALE   14'h000A
`define ASI_PM_EXT       2'h3
`define ASI_SYNC_SCLK    0
`define ASI_SYNC_CS      1
`define ASI_SYNC_DIN     2
`define ASI_SYNC_SHUTDOWN_PIN    3
`define ASI_SYNC_RST     4'h2

`endif

//--- rtl/asi_pkg.sv
/*
 * Types of the converter serial interface.
 * Assumes asi_defs.svh for the widths it uses.
 */
`include "asi_defs.svh"

package asi_pkg;

    // -------------------------------------------------------------------
    // Sequencer states, Gray coded in declaration order.
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ASI_IDLE  = 3'h0,
        ASI_CTRL  = 3'h1,
        ASI_CONV  = 3'h3,
        ASI_STRB  = 3'h2,
        ASI_SHIFT = 3'h6
    } asi_state_e;

    // Control byte, most significant field first.
    typedef struct packed {
        logic       start;
        logic [2:0] channel_sel;
        logic       polarity_select;
        logic       input_config_select;
        logic       power_mode_hi;
        logic       power_mode_lo;
    } asi_ctrl_s;

    typedef logic [`ASI_RES_W-1:0] asi_result_t;

endpackage : asi_pkg

//--- rtl/asi_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides and a flush.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asi_defs.svh"

module asi_buf #(
    parameter int W = `ASI_RES_W
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [0:1];
    logic         wr_q;
    logic         rd_q;
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    // Full and empty come straight from the entry count.
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage is written only when a word is accepted.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count; a flush drops whatever is held.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else if (flush) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : asi_buf

`default_nettype wire

//--- rtl/asi_top.sv
/*
 * Serial control and readout of a converter: control byte in, result out, strobe, shutdown.
 * Assumes asynchronous link pins sampled by CLOCK and a core result synchronous to CLOCK.
 */
// Behaviour
// - Serial input is captured on each serial clock rising edge.
// - Input bits are ignored while chip select is high.
// - Serial output changes only on serial clock falling edges.
// - Serial output is driven only while chip select is low.
// - Internal mode: strobe low at conversion start, high at its end.
// - External mode: strobe high one serial clock period before MSB decision.
// - External mode: strobe enabled while chip select is low.
// - External mode serial clock duty cycle must be 40% to 60%.
// - Shutdown pin low shuts the block down; otherwise operational.
// - Leading zeros are discarded; first one bit starts the control byte.
// - Control byte: start, channel, polarity, input config, two power bits.
// - Track after fifth control bit, hold after eighth, on falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "asi_defs.svh"
module asi_top
    import asi_pkg::*;
#(
    parameter int CONV_CYC = `ASI_CONV_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    input  wire logic        SCLK,
    input  wire logic        CS_B,
    input  wire logic        DIN,
    input  wire logic        SHUTDOWN_B,
    input  wire asi_result_t SAMPLE,
    output var  logic        DOUT,
    output var  logic        DOUT_OE,
    output var  logic        STROBE,
    output var  logic        STROBE_OE,
    output var  logic        TRACK,
    output var  asi_ctrl_s   CTRL,
    output var  logic        DUTY_ERR
);
    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic [3:0] pins;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] f_q;
    logic [3:0] p_q;
    assign pins = {SHUTDOWN_B, DIN, CS_B, SCLK};
    // Three stages per pin, reset with chip select high and the other pins low, so reset brings no false clock edge.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q <= `ASI_SYNC_RST;
            s2_q <= `ASI_SYNC_RST;
            s3_q <= `ASI_SYNC_RST;
            f_q  <= `ASI_SYNC_RST;
            p_q  <= `ASI_SYNC_RST;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= (s3_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
            p_q  <= f_q;
        end
    end
    logic sclk_rise;
    logic sclk_fall;
    logic cs_hi;
    logic din;
    logic oper;
    assign sclk_rise = f_q[`ASI_SYNC_SCLK] & ~p_q[`ASI_SYNC_SCLK];
    assign sclk_fall = ~f_q[`ASI_SYNC_SCLK] & p_q[`ASI_SYNC_SCLK];
    assign cs_hi     = f_q[`ASI_SYNC_CS];
    assign din       = f_q[`ASI_SYNC_DIN];
    assign oper      = f_q[`ASI_SYNC_SHUTDOWN_PIN];

    // -------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------
    asi_state_e               st_q;
    logic [`ASI_CNT_W-1:0]    cnt_q;
    logic [7:0]               sr_q;
    logic                     ext_q;
    logic                     strb_q;
    logic                     track_q;
    logic                     loaded_q;
    logic [`ASI_RES_W-1:0]    sh_q;
    logic                     dout_q;
    logic [31:0]              conv_q;
    asi_ctrl_s                ctrl_q;
    logic                     abort;
    logic                     push;
    logic                     b_ready;
    logic                     b_valid;
    logic                     pop;
    asi_result_t              b_data;
    assign abort = cs_hi | ~oper;
    assign push  = ((st_q == ASI_STRB) & sclk_fall & ~strb_q) |
                   ((st_q == ASI_CONV) & (conv_q == 32'h0));
    assign pop   = b_valid & sclk_fall & ~loaded_q &
                   (((st_q == ASI_STRB) & strb_q) | (st_q == ASI_SHIFT));
    // Control byte capture, track and hold, conversion and strobe.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_q    <= ASI_IDLE;
            cnt_q   <= '0;
            sr_q    <= 8'h00;
            ext_q   <= 1'b0;
            strb_q  <= 1'b1;
            track_q <= 1'b0;
            conv_q  <= 32'h0;
            ctrl_q  <= '0;
        end else if (abort) begin
            st_q    <= ASI_IDLE;
            cnt_q   <= '0;
            track_q <= 1'b0;
            strb_q  <= ~ext_q;
        end else begin
            case (st_q)
                ASI_IDLE: begin
                    if (sclk_rise && din) begin
                        sr_q  <= 8'h01;
                        cnt_q <= `ASI_CNT_ONE;
                        st_q  <= ASI_CTRL;
                    end
                end
                ASI_CTRL: begin
                    if (sclk_rise) begin
                        sr_q  <= {sr_q[6:0], din};
                        cnt_q <= cnt_q + `ASI_CNT_ONE;
                    end
                    if (sclk_fall && cnt_q == `ASI_TRACK_BIT) begin
                        track_q <= 1'b1;
                    end
                    if (sclk_fall && cnt_q == `ASI_CTRL_BITS) begin
                        track_q <= 1'b0;
                        ctrl_q  <= sr_q;
                        ext_q   <= (sr_q[1:0] == `ASI_PM_EXT);
                        if (sr_q[1:0] == `ASI_PM_EXT) begin
                            strb_q <= 1'b0;
                            st_q <= ASI_STRB;
                        end else begin
                            strb_q <= 1'b0;
                            conv_q <= CONV_CYC;
                            st_q   <= ASI_CONV;
                        end
                    end
                end
                ASI_CONV: begin
                    if (conv_q != 32'h0) begin
                        conv_q <= conv_q - 32'h1;
                    end else if (b_ready) begin
                        strb_q <= 1'b1;
                        st_q   <= ASI_SHIFT;
                    end
                end
                ASI_STRB: begin
                    if (sclk_fall && !strb_q && b_ready) begin
                        strb_q <= 1'b1;
                    end else if (sclk_fall && strb_q) begin
                        strb_q <= 1'b0;
                        st_q   <= ASI_SHIFT;
                    end
                end
                ASI_SHIFT: begin
                    st_q <= ASI_SHIFT;
                end
                default: begin
                    st_q <= ASI_IDLE;
                end
            endcase
        end
    end
    // Result buffer between the conversion and the shifter.
    asi_buf #(
        .W(`ASI_RES_W)
    ) u_buf (
        .clk      (CLOCK),
        .rst_b    (RST_B),
        .flush    (abort),
        .in_valid (push),
        .in_ready (b_ready),
        .in_data  (SAMPLE),
        .out_valid(b_valid),
        .out_ready(pop),
        .out_data (b_data)
    );
    // Result shifter; the output bit moves only on serial clock falls.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            loaded_q <= 1'b0;
            sh_q     <= '0;
            dout_q   <= 1'b0;
        end else if (abort) begin
            loaded_q <= 1'b0;
        end else if (pop) begin
            loaded_q <= 1'b1;
            dout_q   <= b_data[`ASI_RES_W-1];
            sh_q     <= {b_data[`ASI_RES_W-2:0], 1'b0};
        end else if (sclk_fall && loaded_q) begin
            dout_q <= sh_q[`ASI_RES_W-1];
            sh_q   <= {sh_q[`ASI_RES_W-2:0], 1'b0};
        end
    end

    // -------------------------------------------------------------------
    // Serial clock duty check
    // -------------------------------------------------------------------
    logic [`ASI_DUTY_W-1:0] hi_q;
    logic [`ASI_DUTY_W-1:0] lo_q;
    logic [13:0]            hi_x;
    logic [13:0]            per_x;
    logic                   duty_q;
    assign hi_x  = {4'h0, hi_q} * `ASI_DUTY_SCALE;
    assign per_x = ({4'h0, hi_q} + {4'h0, lo_q});
    // Widths of high and low phase; checked at each rising edge in external mode while chip select is low.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            hi_q   <= '0;
            lo_q   <= '0;
            duty_q <= 1'b0;
        end else begin
            if (sclk_rise) begin
                hi_q <= '0;
                if (ext_q && !cs_hi && lo_q != '0 && hi_q != '0) begin
                    duty_q <= (hi_x < per_x * `ASI_DUTY_LO) |
                              (hi_x > per_x * `ASI_DUTY_HI);
                end
            end else if (f_q[`ASI_SYNC_SCLK] && hi_q != `ASI_DUTY_MAX) begin
                hi_q <= hi_q + 1'b1;
            end
            if (sclk_rise) begin
                lo_q <= '0;
            end else if (!f_q[`ASI_SYNC_SCLK] && lo_q != `ASI_DUTY_MAX) begin
                lo_q <= lo_q + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            DOUT      <= 1'b0;
            DOUT_OE   <= 1'b0;
            STROBE    <= 1'b1;
            STROBE_OE <= 1'b0;
            TRACK     <= 1'b0;
            CTRL      <= '0;
            DUTY_ERR  <= 1'b0;
        end else begin
            DOUT      <= dout_q;
            DOUT_OE   <= ~cs_hi & oper;
            STROBE    <= strb_q;
            STROBE_OE <= oper & (~ext_q | ~cs_hi);
            TRACK     <= track_q;
            CTRL      <= ctrl_q;
            DUTY_ERR  <= duty_q;
        end
    end
    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence ext_fall_s;
        ext_q && strb_q && sclk_fall && !abort;
    endsequence
    dout_off_cs_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        cs_hi |=> !DOUT_OE) else $error("Data output driven with select high.");
    dout_fall_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $changed(dout_q) |-> $past(sclk_fall)) else $error("Data moved off a fall.");
    cs_abort_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        cs_hi |=> st_q == ASI_IDLE) else $error("Sequencer ran with select high.");
    start_bit_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (st_q == ASI_IDLE && sclk_rise && din && !abort)
        |=> st_q == ASI_CTRL && cnt_q == `ASI_CNT_ONE) else $error("Start bit missed.");
    track_start_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (st_q == ASI_CTRL && sclk_fall && cnt_q == `ASI_TRACK_BIT && !abort)
        |=> track_q) else $error("Tracking did not start.");
    int_strobe_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $fell(strb_q) && !ext_q |-> st_q == ASI_CONV) else $error("Strobe fell early.");
    ext_strobe_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ext_fall_s |=> !strb_q) else $error("External strobe held past one period.");
    ext_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ext_q && strb_q && !sclk_fall && !abort |=> strb_q) else $error("Strobe pulse cut.");
    strobe_oe_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ext_q && cs_hi |=> !STROBE_OE) else $error("Strobe driven with select high.");
    shutdown_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !oper |=> st_q == ASI_IDLE && !DOUT_OE) else $error("Active in shutdown.");
endmodule : asi_top

`default_nettype wire

//--- tb/asi_host_model.sv
/*
 * Host serial master model: drives the link clock, chip select and data
 * input, and samples the block's outputs just before each clock fall after the leading zeros.
 * Assumes the bench calls one task at a time from a single process.
 */
`timescale 1ns/1ps
`default_nettype none

module asi_host_model (
    output var  logic sclk,
    output var  logic cs_b,
    output var  logic din,
    input  wire logic dout,
    input  wire logic dout_oe,
    input  wire logic strobe,
    input  wire logic strobe_oe,
    input  wire logic track
);
    logic cap_dout [1:32];
    logic cap_strb [1:32];
    logic cap_oe   [1:32];
    logic cap_soe  [1:32];
    logic cap_trk  [1:32];
    logic mid_strb;

    // -------------------------------------------------------------------
    // Frame tasks
    // -------------------------------------------------------------------

    // Link clock stands low and chip select high outside frames.
    initial begin
        sclk     = 1'b0;
        cs_b     = 1'b1;
        din      = 1'b0;
        mid_strb = 1'b1;
    end

    // Bit k of a frame: nz leading zeros, the control byte MSB first, zeros.
    function automatic logic bit_at(input logic [7:0] c, input int nz, input int k);
        return (k > nz && k <= nz + 8) ? c[nz + 8 - k] : 1'b0;
    endfunction : bit_at

    // One frame; data changes well after each rise so hold is three cycles.
    task automatic xfer(input logic [7:0] ctrl, input int nz, input int n,
                        input int hi, input int lo);
        int k;
        int j;
        begin
            #3 cs_b = 1'b0;
            din = bit_at(ctrl, nz, 1);
            #80;
            for (k = 1; k <= n + nz; k++) begin
                j = k - nz;
                sclk = 1'b1;
                #24 din = bit_at(ctrl, nz, k + 1);
                #(hi - 24);
                if (j > 0) begin
                    cap_dout[j] = dout;
                    cap_strb[j] = strobe;
                    cap_oe[j]   = dout_oe;
                    cap_soe[j]  = strobe_oe;
                    cap_trk[j]  = track;
                end
                sclk = 1'b0;
                #lo;
                // Internal clock: no rise until the strobe is back high.
                if (j == 8 && ctrl[1:0] != 2'h3) begin
                    #48 mid_strb = strobe;
                    repeat (300) if (strobe !== 1'b1) #8;
                    #40;
                end
            end
            #32 cs_b = 1'b1;
            din = 1'b0;
            #200;
        end
    endtask : xfer

    // Clock pulses with ones on the data line while chip select stays high.
    task automatic junk();
        begin
            din = 1'b1;
            repeat (8) begin
                #32 sclk = 1'b1;
                #32 sclk = 1'b0;
            end
            din = 1'b0;
            #100;
        end
    endtask : junk

endmodule : asi_host_model

`default_nettype wire

//--- tb/test_adc_serial_interface.sv
/*
 * Self-checking bench of the converter serial interface.
 * Assumes the host model drives the link pins; the bench drives reset,
 * shutdown and the core result at CLOCK rising edges.
 */
`timescale 1ns/1ps
`default_nettype none

module test_adc_serial_interface;
    import asi_pkg::*;

    logic        CLOCK;
    logic        RST_B;
    logic        SHUTDOWN_B;
    asi_result_t SAMPLE;
    wire logic   SCLK;
    wire logic   CS_B;
    wire logic   DIN;
    logic        DOUT;
    logic        DOUT_OE;
    logic        STROBE;
    logic        STROBE_OE;
    logic        TRACK;
    asi_ctrl_s   CTRL;
    logic        DUTY_ERR;
    int          n_fail;
    int          tests_run;
    int          cycles;

    asi_top #(.CONV_CYC(20)) dut (.CLOCK(CLOCK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B),
        .DIN(DIN), .SHUTDOWN_B(SHUTDOWN_B), .SAMPLE(SAMPLE), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
        .STROBE(STROBE), .STROBE_OE(STROBE_OE), .TRACK(TRACK), .CTRL(CTRL),
        .DUTY_ERR(DUTY_ERR));

    asi_host_model host (.sclk(SCLK), .cs_b(CS_B), .din(DIN), .dout(DOUT),
        .dout_oe(DOUT_OE), .strobe(STROBE), .strobe_oe(STROBE_OE), .track(TRACK));

    // -------------------------------------------------------------------
    // Clock, timeout and reporting
    // -------------------------------------------------------------------

    // System clock of 8 ns.
    always #4 CLOCK = ~CLOCK;

    // A hang ends the run as a failure.
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %b", $time, what, got);
        end
    endtask : chk1

    task automatic chk_ctrl(input asi_ctrl_s got, input logic [7:0] exp);
        tests_run++;
        if (got !== asi_ctrl_s'(exp)) begin
            n_fail++;
            $display("[ERR] %0t control byte %h", $time, got);
        end
    endtask : chk_ctrl

    task automatic finish_test();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------

    // External clock frame: strobe pulse, track window, result bits.
    task automatic t_ext(input logic [7:0] c, input int nz, input asi_result_t s);
        int i;
        begin
            @(posedge CLOCK) SAMPLE <= s;
            host.xfer(c, nz, 21, 32, 32);
            chk_ctrl(CTRL, c);
            chk1(host.cap_trk[5], 1'b0, "track early");
            chk1(host.cap_trk[6], 1'b1, "track on");
            chk1(host.cap_trk[9], 1'b0, "track off");
            chk1(host.cap_strb[9], 1'b0, "strobe early");
            chk1(host.cap_strb[10], 1'b1, "strobe pulse");
            chk1(host.cap_strb[11], 1'b0, "strobe late");
            chk1(host.cap_oe[1], 1'b1, "dout enable");
            chk1(host.cap_soe[5], 1'b1, "strobe enable");
            for (i = 0; i < 10; i++)
                chk1(host.cap_dout[11 + i], s[9 - i], "ext result bit");
            chk1(host.cap_dout[21], 1'b0, "trailing zero");
            chk1(DOUT_OE, 1'b0, "dout disable");
            chk1(STROBE_OE, 1'b0, "strobe disable");
            chk1(DUTY_ERR, 1'b0, "duty ok");
        end
    endtask : t_ext

    // Internal clock frames for every non-external power mode.
    task automatic t_int();
        int          i;
        logic [7:0]  c;
        asi_result_t s;
        begin
            for (int pm = 0; pm < 3; pm++) begin
                c = {1'b1, 3'h5, 1'b0, 1'b1, pm[1:0]};
                s = 10'h155 + 10'(pm);
                @(posedge CLOCK) SAMPLE <= s;
                host.xfer(c, 0, 20, 32, 32);
                chk_ctrl(CTRL, c);
                chk1(host.mid_strb, 1'b0, "busy strobe");
                chk1(host.cap_strb[9], 1'b1, "done strobe");
                for (i = 0; i < 10; i++)
                    chk1(host.cap_dout[10 + i], s[9 - i], "int result bit");
                chk1(STROBE_OE, 1'b1, "strobe driven");
            end
        end
    endtask : t_int

    // Bits clocked with chip select high leave the control byte alone.
    task automatic t_cs_high();
        host.junk();
        chk_ctrl(CTRL, 8'hD6);
    endtask : t_cs_high

    // Shutdown pin low: a frame is ignored and the data output is not driven.
    task automatic t_shutdown_pin();
        @(posedge CLOCK) SHUTDOWN_B <= 1'b0;
        host.xfer(8'h8F, 0, 21, 32, 32);
        chk_ctrl(CTRL, 8'hD6);
        chk1(host.cap_oe[5], 1'b0, "shutdown output");
        @(posedge CLOCK) SHUTDOWN_B <= 1'b1;
        repeat (10) @(posedge CLOCK);
    endtask : t_shutdown_pin

    // A lopsided link clock in external mode is flagged.
    task automatic t_duty();
        host.xfer(8'hFF, 0, 21, 40, 88);
        chk1(DUTY_ERR, 1'b1, "duty flag");
    endtask : t_duty

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------

    // Reset for ten cycles, then the scenarios.
    initial begin
        CLOCK      = 1'b0;
        RST_B      = 1'b0;
        SHUTDOWN_B = 1'b1;
        SAMPLE     = 10'h000;
        n_fail     = 0;
        tests_run  = 0;
        cycles     = 0;
        repeat (10) @(posedge CLOCK);
        RST_B <= 1'b1;
        repeat (6) @(posedge CLOCK);
        chk1(STROBE, 1'b1, "idle strobe");
        t_ext(8'hFF, 0, 10'h2B5);
        t_ext(8'hA7, 3, 10'h16A);
        t_int();
        t_cs_high();
        t_shutdown_pin();
        t_duty();
        t_ext(8'hB3, 0, 10'h3C1);
        finish_test();
    end

endmodule : test_adc_serial_interface

`default_nettype wire
